// *** scks_pkg.sv ***
// Package: register map, field layout, timing constants and types
package scks_pkg;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // Control and settings
  localparam logic [7:0] ADDR_STATUS  = 8'h04; // Live state (read only)
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08; // Sticky events (read only)
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0c; // Event enables
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10; // Event clear (write only)

  // Control register field positions
  localparam int CTRL_CATCH_LSB   = 0; // spin_catch_select[1:0]
  localparam int CTRL_STOPKEY_BIT = 2; // stop_key_enable
  localparam int CTRL_KEYPAD_BIT  = 3; // Keypad reference mode
  localparam int CTRL_OPEN_BIT    = 4; // Open-loop mode when set
  localparam int CTRL_VMODE_LSB   = 5; // Voltage mode [6:5]
  localparam int CTRL_ENABLE_BIT  = 7; // Drive enable

  // Reset values
  localparam logic [1:0] CATCH_RESET   = 2'h0;
  localparam logic       STOPKEY_RESET = 1'b0;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // Event bit positions
  localparam int EV_START   = 0;
  localparam int EV_STOPKEY = 1;
  localparam int EV_TRIPCLR = 2;
  localparam int EV_UVCLR   = 3;
  localparam int EV_NUM     = 4;

  // Timing at a 10 MHz tick
  localparam int CLK_HZ       = 10_000_000;
  localparam int DETECT_MS    = 200;
  localparam int BOTHRUN_MS   = 60;
  localparam int DETECT_CYC   = DETECT_MS * (CLK_HZ / 1000);
  localparam int BOTHRUN_CYC  = BOTHRUN_MS * (CLK_HZ / 1000);

  // Catch-spinning setting decode
  typedef enum logic [1:0] {
    SCKS_CATCH_OFF = 2'h0,
    SCKS_CATCH_ALL = 2'h1,
    SCKS_CATCH_POS = 2'h2,
    SCKS_CATCH_NEG = 2'h3
  } scks_catch_t;

  // Voltage mode field
  typedef enum logic [1:0] {
    SCKS_VM_FIXED_BOOST  = 2'h0,
    SCKS_VM_SQUARE_LAW   = 2'h1,
    SCKS_VM_INITIAL_RAMP = 2'h2,
    SCKS_VM_EVERY_START  = 2'h3
  } scks_vmode_t;

  // Start outcome presented to the ramp logic
  typedef struct packed {
    logic        load;       // One-cycle load of the start reference
    logic        from_speed; // Load from motor speed, else zero
    logic [1:0]  dir_limit;  // 0 any, 1 positive only, 2 negative only
  } scks_start_t;

endpackage : scks_pkg

// *** scks_sequencer.sv ***
// Spin-catch start and stop-key sequencer with an APB register slave
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module scks_sequencer
  import scks_pkg::*;
#(
  parameter int DETECT_CYCLES  = DETECT_CYC,
  parameter int BOTHRUN_CYCLES = BOTHRUN_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_stop_key,
  input  wire logic        i_run_fwd,
  input  wire logic        i_run_rev,
  input  wire logic        i_run,
  input  wire logic        i_trip,
  input  wire logic        i_uv_trip,
  input  wire logic        i_dc_link_ok,
  input  wire logic        i_detect_shorten,
  output logic             o_run,
  output logic             o_tripped,
  output logic             o_uv_tripped,
  output logic             o_detecting,
  output scks_start_t      o_start,
  output logic             o_irq
);

  // Pin synchronisers, two flops each
  logic [7:0] sync1;
  logic [7:0] sync2;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end
    else
    begin
      sync1 <= {i_detect_shorten, i_dc_link_ok, i_uv_trip, i_trip,
                i_run, i_run_rev, i_run_fwd, i_stop_key};
      sync2 <= sync1;
    end
  end

  logic key_s, fwd_s, rev_s, run_s, trip_s, uv_s, dcok_s, short_s;
  assign {short_s, dcok_s, uv_s, trip_s, run_s, rev_s, fwd_s, key_s} = sync2;

  // Control register
  logic [7:0] ctrl;
  logic [EV_NUM-1:0] irq_st;
  logic [EV_NUM-1:0] irq_en;
  logic [EV_NUM-1:0] ev;
  logic              latched_off; // Run refused until a release case
  wire  catch_on  = ctrl[CTRL_CATCH_LSB +: 2] != SCKS_CATCH_OFF;
  wire  open_loop = ctrl[CTRL_OPEN_BIT];
  wire  enable    = ctrl[CTRL_ENABLE_BIT];
  wire  [1:0] vmode = ctrl[CTRL_VMODE_LSB +: 2];
  // Keypad mode overrides the stop-key enable bit
  wire  key_enabled = ctrl[CTRL_STOPKEY_BIT] | ctrl[CTRL_KEYPAD_BIT];

  // APB slave: zero-wait, unmapped addresses answer with pslverr
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire mapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
                paddr == ADDR_IRQ_ST || paddr == ADDR_IRQ_EN ||
                paddr == ADDR_IRQ_CLR;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite)
      begin
        case (paddr)
          ADDR_CTRL:   prdata <= {24'h000000, ctrl};
          ADDR_STATUS: prdata <= {26'h0, o_detecting, o_uv_tripped,
                                  o_tripped, o_run, latched_off, enable};
          ADDR_IRQ_ST: prdata <= {28'h0, irq_st};
          ADDR_IRQ_EN: prdata <= {28'h0, irq_en};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Settings write; stop-key enable and catch reset to zero
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      ctrl <= CTRL_RESET;
    else if (wr && pready && paddr == ADDR_CTRL)
      ctrl <= pwdata[7:0];
  end

  // Stop-key edge, one action per press
  logic key_d;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      key_d <= 1'b0;
    else
      key_d <= key_s;
  end
  wire key_press = key_s & ~key_d;

  // Forward and reverse held together for the release time
  logic [$clog2(BOTHRUN_CYCLES+1)-1:0] both_cnt;
  wire both_done = both_cnt == ($bits(both_cnt))'(BOTHRUN_CYCLES);
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      both_cnt <= '0;
    else if (!(fwd_s & rev_s))
      both_cnt <= '0;
    else if (!both_done)
      both_cnt <= both_cnt + 1'b1;
  end

  // Trip state; undervoltage needs the DC link, never the key
  logic tripped_q;
  wire  trip_clr = key_press & tripped_q & ~trip_s;
  wire  uv_clr   = o_uv_tripped & dcok_s & ~uv_s;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      tripped_q    <= 1'b0;
      o_uv_tripped <= 1'b0;
    end
    else
    begin
      if (trip_s)
        tripped_q <= 1'b1;
      else if (trip_clr)
        tripped_q <= 1'b0;
      if (uv_s)
        o_uv_tripped <= 1'b1;
      else if (uv_clr)
        o_uv_tripped <= 1'b0;
    end
  end

  // Run latch-off after a stop key or trip removes the run
  wire  release_ok = ~(fwd_s | rev_s | run_s) | ~enable |
                     both_done | o_uv_tripped;
  wire  stop_ev = key_press & ((key_enabled & o_run) | tripped_q);
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      latched_off <= 1'b0;
    else if (stop_ev | trip_s)
      latched_off <= 1'b1;
    else if (release_ok)
      latched_off <= 1'b0;
  end

  // Run demand; the key press itself never raises run
  wire want_run = enable & (fwd_s | rev_s | run_s) & ~tripped_q &
                  ~o_uv_tripped & ~trip_s & ~uv_s & ~latched_off &
                  ~stop_ev;

  // Start sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_DETECT, ST_RUN} scks_state_t;
  scks_state_t state;
  logic [$clog2(DETECT_CYCLES+1)-1:0] det_cnt;
  logic powered_first; // First enable since power-up still pending
  logic stopped_state; // Drive in stop state from a previous run
  wire  det_len_end = short_s ?
        det_cnt >= ($bits(det_cnt))'(DETECT_CYCLES / 2) :
        det_cnt >= ($bits(det_cnt))'(DETECT_CYCLES);
  wire  skip_detect = stopped_state |
        (powered_first && vmode == SCKS_VM_INITIAL_RAMP) |
        (vmode == SCKS_VM_EVERY_START);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state         <= ST_IDLE;
      det_cnt       <= '0;
      powered_first <= 1'b1;
      stopped_state <= 1'b0;
      o_run         <= 1'b0;
      o_detecting   <= 1'b0;
      o_start       <= '0;
    end
    else
    begin
      o_start.load <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (want_run)
          begin
            powered_first <= 1'b0;
            o_start.dir_limit <= ctrl[CTRL_CATCH_LSB +: 2] ==
                                 SCKS_CATCH_POS ? 2'h1 :
                                 ctrl[CTRL_CATCH_LSB +: 2] ==
                                 SCKS_CATCH_NEG ? 2'h2 : 2'h0;
            if (open_loop && catch_on && !skip_detect)
            begin
              state       <= ST_DETECT;
              det_cnt     <= '0;
              o_detecting <= 1'b1;
            end
            else
            begin
              state              <= ST_RUN;
              o_run              <= 1'b1;
              o_start.load       <= 1'b1;
              // Open loop without test starts at zero, closed loop
              // follows the catch bit
              o_start.from_speed <= ~open_loop & catch_on;
            end
          end
        end
        ST_DETECT:
        begin
          if (!want_run)
          begin
            state       <= ST_IDLE;
            o_detecting <= 1'b0;
          end
          else if (det_len_end)
          begin
            state              <= ST_RUN;
            o_detecting        <= 1'b0;
            o_run              <= 1'b1;
            o_start.load       <= 1'b1;
            o_start.from_speed <= 1'b1;
          end
          else
            det_cnt <= det_cnt + 1'b1;
        end
        ST_RUN:
        begin
          if (!want_run)
          begin
            state         <= ST_IDLE;
            o_run         <= 1'b0;
            stopped_state <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (!enable)
        stopped_state <= 1'b0;
    end
  end

  // Trip output registered
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_tripped <= 1'b0;
    else
      o_tripped <= tripped_q;
  end

  // Interrupts: set wins over clear
  assign ev = {uv_clr, trip_clr, key_press,
               o_start.load};
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      irq_st <= '0;
      irq_en <= '0;
      o_irq  <= 1'b0;
    end
    else
    begin
      if (wr && pready && paddr == ADDR_IRQ_EN)
        irq_en <= pwdata[EV_NUM-1:0];
      if (wr && pready && paddr == ADDR_IRQ_CLR)
        irq_st <= (irq_st & ~pwdata[EV_NUM-1:0]) | ev;
      else
        irq_st <= irq_st | ev;
      o_irq <= |(irq_st & irq_en);
    end
  end

  // Checks
  a_key_no_start: assert property (@(posedge i_clk) disable iff (i_reset)
    (state == ST_IDLE && stop_ev) |=> !o_run)
    else $error("stop key started the drive");
  a_trip_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    trip_clr |=> !tripped_q ##0 !o_run)
    else $error("trip reset did not hold drive stopped");
  a_uv_key: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_uv_tripped && !dcok_s) |=> o_uv_tripped)
    else $error("undervoltage cleared without link");
  a_stop_runs_off: assert property (@(posedge i_clk) disable iff (i_reset)
    (stop_ev && o_run) |=> ##1 !o_run)
    else $error("enabled stop key did not stop");
  a_keypad_force: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctrl[CTRL_KEYPAD_BIT] && key_press && o_run && state == ST_RUN)
    |=> latched_off)
    else $error("keypad mode stop key ignored");
  a_detect_len: assert property (@(posedge i_clk) disable iff (i_reset)
    (state == ST_DETECT && det_cnt > ($bits(det_cnt))'(DETECT_CYCLES))
    |-> 1'b0)
    else $error("detection ran past its length");
  a_zero_start: assert property (@(posedge i_clk) disable iff (i_reset)
    (state == ST_IDLE && want_run && open_loop && !catch_on)
    |=> o_start.load && !o_start.from_speed)
    else $error("open-loop start not from zero");
  a_rerun_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    latched_off |=> !o_run)
    else $error("run reapplied while latched off");
  a_press_once: assert property (@(posedge i_clk) disable iff (i_reset)
    key_press |=> !key_press)
    else $error("one press gave two events");

  c_detect: cover property (@(posedge i_clk) state == ST_DETECT ##1
    state == ST_RUN);
  c_trip_reset: cover property (@(posedge i_clk) trip_clr);
  c_both_rel: cover property (@(posedge i_clk) both_done && latched_off);

endmodule : scks_sequencer

// *** scks_partner.sv ***
// Keypad, run terminals and supply lines facing the sequencer
`timescale 1ns/1ps
module scks_partner (
  input  wire logic i_clk,
  output logic      o_stop_key,
  output logic      o_fwd,
  output logic      o_rev,
  output logic      o_run_cmd,
  output logic      o_trip,
  output logic      o_uv,
  output logic      o_dc_ok,
  output logic      o_short
);
  // Idle: no key, no run, no fault, link healthy
  initial
  begin
    {o_stop_key, o_fwd, o_rev, o_run_cmd} = 4'h0;
    {o_trip, o_uv, o_dc_ok, o_short} = 4'h2;
  end

  // Clean press held well past the two-flop synchroniser
  task automatic press();
    o_stop_key <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_stop_key <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : press

  // Run lines as {forward, reverse, run}
  task automatic cmd(input logic [2:0] v);
    {o_fwd, o_rev, o_run_cmd} <= v;
    repeat (6) @(posedge i_clk);
  endtask : cmd

  // Fault lines as {trip, undervoltage, link ok, short test}
  task automatic lines(input logic [3:0] v);
    {o_trip, o_uv, o_dc_ok, o_short} <= v;
    repeat (6) @(posedge i_clk);
  endtask : lines
endmodule : scks_partner

// *** spin_catch_and_stop_key_sequencer_tb.sv ***
// Self-checking bench for the spin-catch and stop-key sequencer
`timescale 1ns/1ps
module spin_catch_and_stop_key_sequencer_tb
  import scks_pkg::*;
();
  localparam int DET = 20; // Shortened detection length
  logic        i_clk;
  logic        i_reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sk, rf, rr, rn, tr, uv, ok, sh;
  logic        o_run;
  logic        o_tripped;
  logic        o_uv_tripped;
  logic        o_detecting;
  logic        o_irq;
  scks_start_t o_start;
  logic [32:0] exp_rd[$];
  scks_start_t exp_st[$];
  int          err_total;
  int          checks;
  int          det_n;
  int          cyc;
  int          rs;
  logic        rnd;

  // Clock at 10 MHz
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  scks_sequencer #(.DETECT_CYCLES(DET), .BOTHRUN_CYCLES(6)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_stop_key(sk), .i_run_fwd(rf),
    .i_run_rev(rr), .i_run(rn), .i_trip(tr), .i_uv_trip(uv),
    .i_dc_link_ok(ok), .i_detect_shorten(sh), .o_run(o_run),
    .o_tripped(o_tripped), .o_uv_tripped(o_uv_tripped),
    .o_detecting(o_detecting), .o_start(o_start), .o_irq(o_irq));

  scks_partner u_part (.i_clk(i_clk), .o_stop_key(sk), .o_fwd(rf),
    .o_rev(rr), .o_run_cmd(rn), .o_trip(tr), .o_uv(uv), .o_dc_ok(ok),
    .o_short(sh));

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic bad(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : bad

  task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) bad($sformatf("read %h want %h", g, e));
  endtask : cmp_rd

  task automatic cmp_st(input scks_start_t g, input scks_start_t e);
    checks++;
    if (g !== e) bad($sformatf("start %h want %h", g, e));
  endtask : cmp_st

  task automatic cmp_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) bad(m);
  endtask : cmp_bit

  // Control word from {enable, open loop, keypad, key enable}
  function automatic logic [31:0] ctl(input logic [3:0] f,
                                      input logic [1:0] vm,
                                      input logic [1:0] c);
    return {24'h0, f[3], vm, f[2], f[1], f[0], c};
  endfunction : ctl

  function automatic scks_start_t st(input logic fs, input logic [1:0] d);
    return '{1'b1, fs, d};
  endfunction : st

  // One APB transfer; holds everything until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Enable with a setting, raise one run line at random, await the start
  task automatic start(input logic [31:0] c, input scks_start_t e,
                       input int d);
    apb(1'b1, ADDR_CTRL, c);
    det_n = 0;
    exp_st.push_back(e);
    // Any one of forward, reverse or run asks for a start
    u_part.cmd(3'h4 >> ($urandom % 3));
    for (int k = 0; k < 300 && exp_st.size() > 0; k++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    cmp_bit(det_n + 1 >= d && det_n <= d + 1, 1'b1, "test length");
    cmp_bit(o_run, 1'b1, "not running");
  endtask : start

  // Drop run and disable so the next start is not from stop state
  task automatic idle();
    u_part.cmd(3'h0);
    apb(1'b1, ADDR_CTRL, 32'h0);
  endtask : idle

  // Watcher pairs each outcome with the oldest note
  always @(posedge i_clk)
  begin
    cyc++;
    if (o_detecting === 1'b1) det_n++;
    if (psel && penable && !pwrite && pready === 1'b1)
      if (exp_rd.size() == 0) bad("stray read");
      else cmp_rd({pslverr, prdata}, exp_rd.pop_front());
    if (o_start.load === 1'b1)
      if (exp_st.size() == 0) bad("stray start");
      else cmp_st(o_start, exp_st.pop_front());
    if (cyc > 20000)
    begin
      bad("timeout");
      results();
    end
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    i_reset = 1'b1;
    {err_total, checks, det_n, cyc} = 128'h0;
    rs = $urandom(44820);
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(ADDR_CTRL, 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    $display("reset map done");
    start(ctl(4'hc, 2'h0, 2'h0), st(1'b0, 2'h0), 0);
    idle();
    // Every catch setting from 1 to 3, test length shortened at random
    for (int c = 1; c < 4; c++)
    begin
      rnd = 1'($urandom % 2);
      u_part.lines({3'h1, rnd});
      start(ctl(4'hc, 2'h0, 2'(c)), st(1'b1, 2'(c == 1 ? 0 : c - 1)),
            rnd ? DET / 2 : DET);
      idle();
    end
    u_part.lines(4'h2);
    $display("open loop done");
    // Stop state restart, then every-start voltage mode
    start(ctl(4'hc, 2'h0, 2'h1), st(1'b1, 2'h0), DET);
    u_part.cmd(3'h0);
    start(ctl(4'hc, 2'h0, 2'h1), st(1'b0, 2'h0), 0);
    idle();
    start(ctl(4'hc, 2'h3, 2'h1), st(1'b0, 2'h0), 0);
    idle();
    start(ctl(4'h8, 2'h0, 2'h1), st(1'b1, 2'h0), 0);
    idle();
    start(ctl(4'h8, 2'h0, 2'h0), st(1'b0, 2'h0), 0);
    $display("closed loop done");
    // Enabled key stops, flags, then refuses held run
    apb(1'b1, ADDR_IRQ_CLR, 32'hf);
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    apb(1'b1, ADDR_CTRL, ctl(4'h9, 2'h0, 2'h0));
    rd(ADDR_CTRL, {1'b0, ctl(4'h9, 2'h0, 2'h0)});
    u_part.press();
    cmp_bit(o_run, 1'b0, "key no stop");
    cmp_bit(o_irq, 1'b1, "irq low");
    rd(ADDR_IRQ_ST, 33'h2);
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge i_clk);
    cmp_bit(o_irq, 1'b0, "irq unmasked");
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    apb(1'b1, ADDR_IRQ_CLR, 32'h2);
    repeat (2) @(posedge i_clk);
    cmp_bit(o_irq, 1'b0, "irq not cleared");
    repeat (10) @(posedge i_clk);
    cmp_bit(o_run, 1'b0, "held run restarted");
    rd(ADDR_STATUS, 33'h3);
    u_part.press();
    cmp_bit(o_run, 1'b0, "key started drive");
    u_part.cmd(3'h0);
    start(ctl(4'h9, 2'h0, 2'h0), st(1'b0, 2'h0), 0);
    // Keypad mode forces the key on
    apb(1'b1, ADDR_CTRL, ctl(4'ha, 2'h0, 2'h0));
    u_part.press();
    cmp_bit(o_run, 1'b0, "keypad no stop");
    // Forward and reverse together release the latch after the hold
    exp_st.push_back(st(1'b0, 2'h0));
    u_part.cmd(3'h6);
    cmp_bit(o_run, 1'b0, "released before hold time");
    repeat (12) @(posedge i_clk);
    cmp_bit(o_run, 1'b1, "both-run release failed");
    u_part.cmd(3'h0);
    $display("stop key done");
    start(ctl(4'h8, 2'h0, 2'h0), st(1'b0, 2'h0), 0);
    apb(1'b1, ADDR_IRQ_CLR, 32'hf);
    u_part.lines(4'ha);
    u_part.lines(4'h2);
    cmp_bit(o_tripped, 1'b1, "trip lost");
    u_part.press();
    cmp_bit(o_tripped, 1'b0, "trip kept");
    cmp_bit(o_run, 1'b0, "trip reset ran");
    rd(ADDR_IRQ_ST, 33'h6);
    u_part.cmd(3'h0);
    u_part.lines(4'h4);
    u_part.press();
    cmp_bit(o_uv_tripped, 1'b1, "uv cleared by key");
    u_part.lines(4'h2);
    repeat (2) @(posedge i_clk);
    cmp_bit(o_uv_tripped, 1'b0, "uv stuck");
    rd(ADDR_IRQ_ST, 33'he);
    $display("trips done");
    // Power-up again: first initial-ramp enable skips the test
    i_reset <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    start(ctl(4'hc, 2'h2, 2'h1), st(1'b0, 2'h0), 0);
    idle();
    start(ctl(4'hc, 2'h2, 2'h1), st(1'b1, 2'h0), DET);
    rd(ADDR_IRQ_ST, 33'h1);
    $display("initial ramp done");
    results();
  end
endmodule : spin_catch_and_stop_key_sequencer_tb
